// [axi_host_model.sv]
// behavioural axi4-lite management host driving the register block
module axi_host_model (
   input  wire logic        clk,     // system clock
   output      logic [7:0]  awaddr,  // write address
   output      logic        awvalid, // write address valid
   input  wire logic        awready, // write address ready
   output      logic [31:0] wdata,   // write data
   output      logic [3:0]  wstrb,   // byte strobes
   output      logic        wvalid,  // write data valid
   input  wire logic        wready,  // write data ready
   input  wire logic [1:0]  bresp,   // write response
   input  wire logic        bvalid,  // write response valid
   output      logic        bready,  // write response ready
   output      logic [7:0]  araddr,  // read address
   output      logic        arvalid, // read address valid
   input  wire logic        arready, // read address ready
   input  wire logic        rvalid,  // read data valid
   output      logic        rready   // read data ready
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   end

   // one write; handshakes are judged before the edge, released after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'h7;
      while (!tb)
      begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid & bready;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
   endtask : wr

   // one read; rready stays up afterwards, and each read drives it high again with arvalid
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      tr = 1'b0;
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      while (!tr)
      begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid & rready;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
   endtask : rd
endmodule : axi_host_model

// [event_flag_bank.sv]
// sticky read-clear event flags with enable gating
module event_flag_bank #(
   parameter int N = 8
) (
   input wire logic clk,   // system clock
   input wire logic reset, // synchronous reset, active high
   flag_if.bank     f      // flags toward the register front end
);

   //----------------------------------------------------------------
   // flag storage
   //----------------------------------------------------------------
   logic [N-1:0] flags_r;
   logic [N-1:0] flags_nxt;

   // a new event wins over the read that clears it
   always_comb
   begin
      flags_nxt = f.events | (f.readClear ? '0 : flags_r); // R2 R3
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         flags_r <= phy_regs_pkg::FLAGS_RST; // R2 R3
      else
         flags_r <= flags_nxt;
   end

   assign f.flags     = flags_r;
   assign f.intActive = |(flags_r & f.enables); // R5

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   AST_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
      (f.events != '0) |=> ((flags_r & $past(f.events)) == $past(f.events))) // R2
      else $error("event did not set its flag");

   AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (reset)
      (f.readClear && f.events == '0) |=> (flags_r == '0)) // R3
      else $error("flag read did not clear flags");

   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (reset)
      (!f.readClear && f.events == '0) |=> $stable(flags_r)) // R3
      else $error("flag changed without event or read");

endmodule : event_flag_bank

// [flag_if.sv]
// signals between the register front end and the event flag bank
interface flag_if #(parameter int N = 8);
   logic [N-1:0] events;    // one-cycle event pulses
   logic [N-1:0] enables;   // per-flag interrupt enables
   logic         readClear; // flag register read this cycle
   logic [N-1:0] flags;     // sticky event flags
   logic         intActive; // an enabled flag is set

   modport bank (input events, input enables, input readClear, output flags, output intActive);
   modport regs (output events, output enables, output readClear, input flags, input intActive);
endinterface : flag_if

// [phy_mgmt_regs.sv]
// phy interrupt, crossover and status registers behind an axi4-lite slave
//
// Function
// R1 - Enables for parallel fault, partner ack, link-down, remote fault, link-up, bits 12..8.
// R2 - Read-clear flags for jabber, receive error, page, parallel fault, bits 7..4.
// R3 - Read-clear flags for partner ack, link-down, remote fault, link-up, bits 3..0.
// R4 - Enables for jabber, receive error, page received in bits 15..13, reset zero.
// R5 - Interrupt active while any flag is set with its enable set.
// R6 - Control bit 14 picks pin polarity: one active high, zero active low.
// R7 - Override bit one disables automatic crossover; zero, the reset value, enables it.
// R8 - With override set, media side bit one gives MDI, zero MDI-X.
// R9 - Jabber counter runs only while its enable bit is one; resets to one.
// R10 - Read-only speed flags: bit 6 gigabit, bit 5 fast, bit 4 ten.
// R11 - Read-only bit 3 reports full duplex as one, half as zero.
// R12 - Read-only bit 2 reports gigabit master as one, slave as zero.
//
// The implementer's own choice: the AXI4-Lite register port.
module phy_mgmt_regs (
   input  wire logic        clk,             // 10 MHz system clock
   input  wire logic        reset,           // synchronous reset, active high
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output      logic        s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output      logic        s_axi_wready,    // write data ready
   output      logic [1:0]  s_axi_bresp,     // write response
   output      logic        s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output      logic        s_axi_arready,   // read address ready
   output      logic [31:0] s_axi_rdata,     // read data
   output      logic [1:0]  s_axi_rresp,     // read response
   output      logic        s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   // events and resolved link state
   input  wire logic [7:0]  eventPulse,      // one-cycle events, bit order of the flags
   input  wire logic        speed1000,       // resolved gigabit
   input  wire logic        speed100,        // resolved fast ethernet
   input  wire logic        speed10,         // resolved ten megabit
   input  wire logic        fullDuplex,      // resolved full duplex
   input  wire logic        gigMaster,       // gigabit master role
   input  wire logic        linkCheckFail,   // link status check failing
   // controls toward the phy
   output      logic        intPin,          // interrupt pin, polarity programmable
   output      logic        autoCrossoverEn, // automatic crossover running
   output      logic        forcedMdi,       // forced mdi: high only when override and media side are both set, else low
   output      logic        jabberCountEn,   // jabber counter enabled
   output      logic        irq              // bus interrupt, active high level
);

   //----------------------------------------------------------------
   // flag bank
   //----------------------------------------------------------------
   flag_if #(.N(phy_regs_pkg::N_EVENTS)) fl ();

   event_flag_bank #(.N(phy_regs_pkg::N_EVENTS)) u_bank (
      .clk   (clk),
      .reset (reset),
      .f     (fl.bank)
   );

   //----------------------------------------------------------------
   // bus write channel
   //----------------------------------------------------------------
   logic        awHeld_r,  awHeld_nxt;
   logic [7:0]  awAddr_r,  awAddr_nxt;
   logic        wHeld_r,   wHeld_nxt;
   logic [31:0] wData_r,   wData_nxt;
   logic [3:0]  wStrb_r,   wStrb_nxt;
   logic        awReady_r, awReady_nxt;
   logic        wReady_r,  wReady_nxt;
   logic        bValid_r,  bValid_nxt;
   logic [1:0]  bResp_r,   bResp_nxt;
   logic        doWrite;
   logic [5:0]  wIdx;
   logic        wMapped;

   assign doWrite = awHeld_r & wHeld_r & ~bValid_r;
   assign wIdx    = phy_regs_pkg::wordIdx(awAddr_r);
   assign wMapped = (wIdx == phy_regs_pkg::IDX_INT) || (wIdx == phy_regs_pkg::IDX_XOVER) ||
                    (wIdx == phy_regs_pkg::IDX_PHYCTL) || (wIdx == phy_regs_pkg::IDX_ISTAT) ||
                    (wIdx == phy_regs_pkg::IDX_IMASK);

   // address and data are taken independently, the response follows both
   always_comb
   begin
      awHeld_nxt = awHeld_r;
      awAddr_nxt = awAddr_r;
      wHeld_nxt  = wHeld_r;
      wData_nxt  = wData_r;
      wStrb_nxt  = wStrb_r;
      bValid_nxt = bValid_r;
      bResp_nxt  = bResp_r;
      if (s_axi_awvalid && awReady_r)
      begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r)
      begin
         wHeld_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (bValid_r && s_axi_bready)
         bValid_nxt = 1'b0;
      if (doWrite)
      begin
         awHeld_nxt = 1'b0;
         wHeld_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = wMapped ? phy_regs_pkg::RESP_OKAY : phy_regs_pkg::RESP_SLVERR;
      end
      awReady_nxt = ~awHeld_nxt;
      wReady_nxt  = ~wHeld_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         awHeld_r  <= 1'b0;
         awAddr_r  <= 8'h00;
         wHeld_r   <= 1'b0;
         wData_r   <= 32'h00000000;
         wStrb_r   <= 4'h0;
         awReady_r <= 1'b0;
         wReady_r  <= 1'b0;
         bValid_r  <= 1'b0;
         bResp_r   <= 2'h0;
      end
      else
      begin
         awHeld_r  <= awHeld_nxt;
         awAddr_r  <= awAddr_nxt;
         wHeld_r   <= wHeld_nxt;
         wData_r   <= wData_nxt;
         wStrb_r   <= wStrb_nxt;
         awReady_r <= awReady_nxt;
         wReady_r  <= wReady_nxt;
         bValid_r  <= bValid_nxt;
         bResp_r   <= bResp_nxt;
      end
   end

   //----------------------------------------------------------------
   // control registers
   //----------------------------------------------------------------
   logic [7:0]  intEn_r,   intEn_nxt;
   logic [15:0] xover_r,   xover_nxt;
   logic [15:0] phyCtl_r,  phyCtl_nxt;
   logic [7:0]  irqStat_r, irqStat_nxt;
   logic [7:0]  irqMask_r, irqMask_nxt;
   logic [4:0]  stat_r,    stat_nxt;
   logic        lscf_r,    lscf_nxt;
   logic [15:0] enWord;

   assign enWord = phy_regs_pkg::mergeWrite({intEn_r, 8'h00}, wData_r, wStrb_r, 16'hff00);

   // writes land in the writable bits only; status bits are sampled every cycle
   always_comb
   begin
      intEn_nxt   = intEn_r;
      xover_nxt   = xover_r;
      phyCtl_nxt  = phyCtl_r;
      irqMask_nxt = irqMask_r;
      irqStat_nxt = irqStat_r;
      if (doWrite)
      begin
         case (wIdx)
            phy_regs_pkg::IDX_INT:    intEn_nxt = enWord[15:8]; // R1 R4
            phy_regs_pkg::IDX_XOVER:  xover_nxt = phy_regs_pkg::mergeWrite(xover_r, wData_r,
                                                     wStrb_r, phy_regs_pkg::XOVER_WMASK); // R7 R8
            phy_regs_pkg::IDX_PHYCTL: phyCtl_nxt = phy_regs_pkg::mergeWrite(phyCtl_r, wData_r,
                                                     wStrb_r, phy_regs_pkg::PHYCTL_WMASK); // R6 R9
            phy_regs_pkg::IDX_IMASK:  irqMask_nxt = wStrb_r[0] ? wData_r[7:0] : irqMask_r;
            phy_regs_pkg::IDX_ISTAT:  irqStat_nxt = wStrb_r[0] ? irqStat_r & ~wData_r[7:0]
                                                               : irqStat_r;
            default:                  intEn_nxt = intEn_r;
         endcase
      end
      // a new event wins over the clearing write
      irqStat_nxt = irqStat_nxt | eventPulse;
      stat_nxt    = {speed1000, speed100, speed10, fullDuplex, gigMaster}; // R10 R11 R12
      lscf_nxt    = linkCheckFail;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         intEn_r   <= phy_regs_pkg::EN_RST;     // R1 R4
         xover_r   <= phy_regs_pkg::XOVER_RST;  // R7
         phyCtl_r  <= phy_regs_pkg::PHYCTL_RST; // R6 R9
         irqStat_r <= 8'h00;
         irqMask_r <= 8'h00;
         stat_r    <= phy_regs_pkg::STAT_RST;   // R10 R11 R12
         lscf_r    <= 1'b0;
      end
      else
      begin
         intEn_r   <= intEn_nxt;
         xover_r   <= xover_nxt;
         phyCtl_r  <= phyCtl_nxt;
         irqStat_r <= irqStat_nxt;
         irqMask_r <= irqMask_nxt;
         stat_r    <= stat_nxt;
         lscf_r    <= lscf_nxt;
      end
   end

   assign fl.events  = eventPulse;
   assign fl.enables = intEn_r;

   //----------------------------------------------------------------
   // bus read channel
   //----------------------------------------------------------------
   logic        arReady_r, arReady_nxt;
   logic        rValid_r,  rValid_nxt;
   logic [31:0] rData_r,   rData_nxt;
   logic [1:0]  rResp_r,   rResp_nxt;
   logic        arTaken;
   logic [5:0]  rIdx;

   assign arTaken      = s_axi_arvalid & arReady_r;
   assign rIdx         = phy_regs_pkg::wordIdx(s_axi_araddr);
   assign fl.readClear = arTaken && (rIdx == phy_regs_pkg::IDX_INT); // R2 R3

   // read mux; the flag word is captured in the same cycle its read clears it
   always_comb
   begin
      rValid_nxt = rValid_r;
      rData_nxt  = rData_r;
      rResp_nxt  = rResp_r;
      if (rValid_r && s_axi_rready)
         rValid_nxt = 1'b0;
      if (arTaken)
      begin
         rValid_nxt = 1'b1;
         rResp_nxt  = phy_regs_pkg::RESP_OKAY;
         case (rIdx)
            phy_regs_pkg::IDX_INT:    rData_nxt = {16'h0000, intEn_r, fl.flags}; // R2 R3
            phy_regs_pkg::IDX_XOVER:  rData_nxt = {16'h0000, xover_r};
            phy_regs_pkg::IDX_PHYCTL: rData_nxt = {16'h0000, phyCtl_r[15:7], stat_r,
                                                   phyCtl_r[1], lscf_r}; // R10 R11 R12
            phy_regs_pkg::IDX_ISTAT:  rData_nxt = {24'h000000, irqStat_r};
            phy_regs_pkg::IDX_IMASK:  rData_nxt = {24'h000000, irqMask_r};
            default:
            begin
               rData_nxt = 32'h00000000;
               rResp_nxt = phy_regs_pkg::RESP_SLVERR;
            end
         endcase
      end
      arReady_nxt = ~rValid_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         arReady_r <= 1'b0;
         rValid_r  <= 1'b0;
         rData_r   <= 32'h00000000;
         rResp_r   <= 2'h0;
      end
      else
      begin
         arReady_r <= arReady_nxt;
         rValid_r  <= rValid_nxt;
         rData_r   <= rData_nxt;
         rResp_r   <= rResp_nxt;
      end
   end

   //----------------------------------------------------------------
   // registered outputs toward the phy
   //----------------------------------------------------------------
   logic intPin_r,  intPin_nxt;
   logic autoX_r,   autoX_nxt;
   logic mdi_r,     mdi_nxt;
   logic jabEn_r,   jabEn_nxt;
   logic irq_r,     irq_nxt;

   // pin level follows polarity; crossover side only matters under override
   always_comb
   begin
      intPin_nxt = phyCtl_r[phy_regs_pkg::PC_POL_BIT] ? fl.intActive : ~fl.intActive; // R5 R6
      autoX_nxt  = ~xover_r[phy_regs_pkg::XO_OVR_BIT];                               // R7
      mdi_nxt    = xover_r[phy_regs_pkg::XO_OVR_BIT] & xover_r[phy_regs_pkg::XO_SIDE_BIT]; // R8
      jabEn_nxt  = phyCtl_r[phy_regs_pkg::PC_JAB_BIT];                              // R9
      irq_nxt    = |(irqStat_r & irqMask_r);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         intPin_r <= 1'b1; // inactive for the low-active reset polarity
         autoX_r  <= 1'b1;
         mdi_r    <= 1'b0;
         jabEn_r  <= 1'b1;
         irq_r    <= 1'b0;
      end
      else
      begin
         intPin_r <= intPin_nxt;
         autoX_r  <= autoX_nxt;
         mdi_r    <= mdi_nxt;
         jabEn_r  <= jabEn_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign s_axi_awready   = awReady_r;
   assign s_axi_wready    = wReady_r;
   assign s_axi_bvalid    = bValid_r;
   assign s_axi_bresp     = bResp_r;
   assign s_axi_arready   = arReady_r;
   assign s_axi_rvalid    = rValid_r;
   assign s_axi_rdata     = rData_r;
   assign s_axi_rresp     = rResp_r;
   assign intPin          = intPin_r;
   assign autoCrossoverEn = autoX_r;
   assign forcedMdi       = mdi_r;
   assign jabberCountEn   = jabEn_r;
   assign irq             = irq_r;

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   sequence seqEnWrite;
      doWrite && (wIdx == phy_regs_pkg::IDX_INT) && (wStrb_r[1]);
   endsequence

   sequence seqCtlRead;
      arTaken && (rIdx == phy_regs_pkg::IDX_PHYCTL);
   endsequence

   AST_EN_WRITE: assert property (@(posedge clk) disable iff (reset)
      seqEnWrite |=> (intEn_r == $past(wData_r[15:8]))) // R1
      else $error("enable write not stored");

   AST_EN_RESET: assert property (@(posedge clk)
      $past(reset) |-> (intEn_r == 8'h00 && jabEn_nxt == 1'b1)) // R4
      else $error("enables or jabber enable wrong after reset");

   AST_PIN_LEVEL: assert property (@(posedge clk) disable iff (reset)
      ##1 (intPin_r == ($past(phyCtl_r[14]) ? |($past(fl.flags & intEn_r))
                                             : ~|($past(fl.flags & intEn_r))))) // R5
      else $error("interrupt pin level wrong");

   AST_PIN_POL: assert property (@(posedge clk) disable iff (reset)
      (!fl.intActive && !phyCtl_r[14]) ##1 (!fl.intActive && !phyCtl_r[14]) |-> intPin_r) // R6
      else $error("low-active pin not idle high");

   AST_XOVER: assert property (@(posedge clk) disable iff (reset)
      ##1 (autoX_r == !$past(xover_r[6]))) // R7
      else $error("crossover override not applied");

   AST_MDI: assert property (@(posedge clk) disable iff (reset)
      !xover_r[6] |=> !mdi_r) // R8
      else $error("media side acted without override");

   AST_JAB: assert property (@(posedge clk) disable iff (reset)
      ##1 (jabEn_r == $past(phyCtl_r[9]))) // R9
      else $error("jabber enable not followed");

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (reset)
      seqCtlRead |=> (rValid_r && rData_r[6:2] == $past(stat_r))) // R10 R11 R12
      else $error("resolved status misreported");

   AST_WRITE_RESP: assert property (@(posedge clk) disable iff (reset)
      (awHeld_r && wHeld_r && !bValid_r) |=> bValid_r) // AXI4-Lite write port, the implementer's own choice
      else $error("write response missing");

endmodule : phy_mgmt_regs

// [phy_regs_pkg.sv]
// constants, offsets, field positions and helpers for the phy management register block
package phy_regs_pkg;

   //----------------------------------------------------------------
   // register indices (byte address is four times the index)
   //----------------------------------------------------------------
   localparam logic [5:0] IDX_INT    = 6'h1b; // interrupt enables and event flags
   localparam logic [5:0] IDX_XOVER  = 6'h1c; // crossover control
   localparam logic [5:0] IDX_PHYCTL = 6'h1f; // phy control and resolved status
   localparam logic [5:0] IDX_ISTAT  = 6'h20; // bus interrupt status, write one to clear
   localparam logic [5:0] IDX_IMASK  = 6'h21; // bus interrupt mask

   //----------------------------------------------------------------
   // field positions
   //----------------------------------------------------------------
   localparam int N_EVENTS    = 8;  // event flags in bits 7..0
   localparam int INT_EN_LSB  = 8;  // enables in bits 15..8
   localparam int XO_OVR_BIT  = 6;  // crossover override
   localparam int XO_SIDE_BIT = 7;  // forced media side
   localparam int PC_POL_BIT  = 14; // interrupt pin polarity
   localparam int PC_JAB_BIT  = 9;  // jabber counter enable
   localparam int PC_STAT_LSB = 2;  // speed/duplex/role field 6..2
   localparam int PC_LSCF_BIT = 0;  // link status check fail

   //----------------------------------------------------------------
   // reset values and writable masks
   //----------------------------------------------------------------
   localparam logic [15:0] XOVER_RST    = 16'h0000;
   localparam logic [15:0] PHYCTL_RST   = 16'h0200;
   localparam logic [15:0] XOVER_WMASK  = 16'hffff;
   localparam logic [15:0] PHYCTL_WMASK = 16'hf382;
   localparam logic [7:0]  EN_RST       = 8'h00;
   localparam logic [7:0]  FLAGS_RST    = 8'h00;
   localparam logic [4:0]  STAT_RST     = 5'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   // merge a strobed bus write into the writable bits of a 16-bit register
   function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb,
                                              input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      return (old & ~lanes) | (data[15:0] & lanes);
   endfunction : mergeWrite

   // word index of a byte address
   function automatic logic [5:0] wordIdx(input logic [7:0] addr);
      return addr[7:2];
   endfunction : wordIdx

endpackage : phy_regs_pkg

// [testbench.sv]
// self-checking bench for the phy management register block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
   localparam logic [1:0] OK  = phy_regs_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = phy_regs_pkg::RESP_SLVERR;
   logic        clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, intPin, autoCrossoverEn, forcedMdi;
   logic        jabberCountEn, irq, speed1000, speed100, speed10;
   logic        fullDuplex, gigMaster, linkCheckFail;
   logic [7:0]  awaddr, araddr, eventPulse;
   logic [31:0] wdata, rdata, rng;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp, kb;
   logic [33:0] expQ[$];
   logic [33:0] expV;
   int          failures, samplesChecked, cycles;

   phy_mgmt_regs i_dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .eventPulse(eventPulse), .speed1000(speed1000),
      .speed100(speed100), .speed10(speed10), .fullDuplex(fullDuplex),
      .gigMaster(gigMaster), .linkCheckFail(linkCheckFail), .intPin(intPin),
      .autoCrossoverEn(autoCrossoverEn), .forcedMdi(forcedMdi),
      .jabberCountEn(jabberCountEn), .irq(irq));
   axi_host_model i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
      .rready(rready));

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : nextRand
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic rdExp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      expQ.push_back({rs, d});
      i_host.rd(a);
   endtask : rdExp
   task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      i_host.wr(a, d, resp);
      `CHK("bresp", rs, resp)
      tick(2);
   endtask : wrChk
   task automatic pulse(input logic [7:0] e);
      eventPulse <= e;
      @(posedge clk);
      eventPulse <= 8'h00;
      tick(3);
   endtask : pulse
   // order: intPin, autoCrossoverEn, forcedMdi, jabberCountEn, irq
   task automatic outs(input logic [4:0] e);
      `CHK("outputs", e, {intPin, autoCrossoverEn, forcedMdi, jabberCountEn, irq})
   endtask : outs
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end
   // compare each read answer with the oldest note
   always @(posedge clk)
      if (rvalid && rready)
      begin
         expV = (expQ.size() > 0) ? expQ.pop_front() : 34'hx;
         `CHK("rdata", expV, {rresp, rdata})
      end

   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      eventPulse = 8'h00;
      {speed1000, speed100, speed10, fullDuplex, gigMaster, linkCheckFail} = 6'h00;
      rng = 32'h2b;
      tick(4);
      reset <= 1'b0;
      tick(2);
      outs(5'h1a);
      rdExp(8'h6c, 32'h0, OK);
      rdExp(8'h70, 32'h0, OK);
      rdExp(8'h7c, 32'h0200, OK);
      wrChk(8'h6c, 32'h00ff, OK);
      rdExp(8'h6c, 32'h0, OK);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         rng = nextRand(rng);
         wrChk(8'h6c, {16'h0, 8'h01 << i, 8'h00}, OK);
         pulse(rng[7:0] & ~(8'h01 << i));
         outs(5'h1a);
         pulse(8'h01 << i);
         outs(5'h0a);
         rdExp(8'h6c, {16'h0, 8'h01 << i, rng[7:0] | (8'h01 << i)}, OK);
         tick(2);
         outs(5'h1a);
      end
      $display("test flags done");
      wrChk(8'h7c, 32'h4200, OK);
      outs(5'h0a);
      pulse(8'h80);
      outs(5'h1a);
      rdExp(8'h6c, 32'h8080, OK);
      tick(2);
      outs(5'h0a);
      $display("test polarity done");
      rdExp(8'h80, 32'hff, OK);
      wrChk(8'h84, 32'h01, OK);
      outs(5'h0b);
      wrChk(8'h80, 32'hfe, OK);
      rdExp(8'h80, 32'h01, OK);
      wrChk(8'h80, 32'h01, OK);
      outs(5'h0a);
      pulse(8'h02);
      outs(5'h0a);
      wrChk(8'h84, 32'h02, OK);
      outs(5'h0b);
      rdExp(8'h84, 32'h02, OK);
      wrChk(8'h80, 32'hff, OK);
      $display("test bus interrupt done");
      for (int k = 0; k < 4; k++)
      begin
         rng = nextRand(rng);
         kb = k[1:0];
         wrChk(8'h70, {16'h0, rng[15:8], kb, rng[5:0]}, OK);
         outs({1'b0, ~kb[0], kb[1] & kb[0], 2'h2});
         rdExp(8'h70, {16'h0, rng[15:8], kb, rng[5:0]}, OK);
      end
      $display("test crossover done");
      for (int k = 0; k < 3; k++)
      begin
         rng = nextRand(rng);
         {speed1000, speed100, speed10} <= 3'h4 >> k;
         {fullDuplex, gigMaster, linkCheckFail} <= rng[2:0];
         wrChk(8'h7c, {16'h0, 6'h10, rng[9], 9'h0}, OK);
         outs({3'h1, rng[9], 1'b0});
         rdExp(8'h7c, {16'h0, 6'h10, rng[9], 2'h0, 3'h4 >> k, rng[2:1], 1'b0, rng[0]},
               OK);
      end
      $display("test status done");
      wrChk(8'h40, 32'hffff, ERR);
      rdExp(8'h40, 32'h0, ERR);
      $display("test unmapped done");
      tick(2);
      complete_run();
   end
endmodule : testbench
